// ---- rtl/ten_point_linearizer.sv ----
// ten point linearizer: curve scaling, offset and units tag
// assumes an AXI4-Lite master and an upstream sample strobe
// How it works
// - ten input/output point pairs plus one offset are held in registers
// - Off mode passes the input through with the offset added
// - interpolated mode draws straight lines between neighbouring points
// - stepped mode holds a point's output until the next point is reached
// - interpolated inputs at or below point one give output one
// - an input equal to a point's input yields that point's output
// - the offset is added after scaling in every mode
// - points and offset take signed milli-units within +/-99999.000
// - output carries a chosen unit; source copies the input's unit
// - stepped inputs below point two give output one
// - an input error passes to the output instead of a value
`timescale 1ns/1ps
`default_nettype none
module ten_point_linearizer
   import lin_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // register bus
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // upstream sample
   input  wire logic        in_valid,
   output logic             in_ready,
   input  wire logic [31:0] in_value,
   input  wire logic        in_error,
   input  wire logic [2:0]  in_unit,
   // downstream result
   output logic             out_valid,
   output logic [31:0]      out_value,
   output logic             out_error,
   output logic [2:0]       out_unit
);
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   function automatic logic [31:0] clamp_val(input logic [31:0] v);
      if ($signed(v) > $signed(VAL_MAX)) return VAL_MAX;
      if ($signed(v) < $signed(VAL_MIN)) return VAL_MIN;
      return v;
   endfunction
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[8*b +: 8] = d[8*b +: 8];
      end
      return r;
   endfunction
   // {hit, index} for a point table at base
   function automatic logic [4:0] pt_hit(input logic [7:0] a,
                                         input logic [7:0] base);
      logic [7:0] rel;
      rel = a - base;
      if (a >= base && rel[1:0] == 2'b00 && rel[7:2] < 6'(NPTS))
         return {1'b1, rel[5:2]};
      return 5'h00;
   endfunction
   // ------------------------------------------------
   // configuration registers and bus slave
   // ------------------------------------------------
   logic signed [31:0] xq [NPTS];
   logic signed [31:0] yq [NPTS];
   logic signed [31:0] xd [NPTS];
   logic signed [31:0] yd [NPTS];
   logic [1:0]  fn_q, fn_d;
   logic [2:0]  unit_q, unit_d;
   logic [31:0] off_q, off_d;
   logic [7:0]  awa_q, awa_d;
   logic        awh_q, awh_d, awr_q, awr_d;
   logic [31:0] wda_q, wda_d;
   logic [3:0]  wst_q, wst_d;
   logic        wh_q, wh_d, wr_q, wr_d;
   logic        bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   logic [31:0] rd_q, rd_d;
   logic        busy_q, err_q, seen_q;
   logic [4:0]  wx, wy, rx, ry;
   always_comb begin
      xd = xq;
      yd = yq;
      fn_d = fn_q;
      unit_d = unit_q;
      off_d = off_q;
      awa_d = awa_q;
      awh_d = awh_q;
      wda_d = wda_q;
      wst_d = wst_q;
      wh_d = wh_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rr_d = rr_q;
      rd_d = rd_q;
      wx = pt_hit(awa_q, XPT_BASE);
      wy = pt_hit(awa_q, YPT_BASE);
      rx = pt_hit(s_axi_araddr, XPT_BASE);
      ry = pt_hit(s_axi_araddr, YPT_BASE);
      if (s_axi_awvalid && awr_q) begin
         awa_d = s_axi_awaddr;
         awh_d = 1'b1;
      end
      if (s_axi_wvalid && wr_q) begin
         wda_d = s_axi_wdata;
         wst_d = s_axi_wstrb;
         wh_d  = 1'b1;
      end
      if (bv_q && s_axi_bready) bv_d = 1'b0;
      // both halves held and the last answer gone: commit the write
      if (awh_q && wh_q && !bv_q) begin
         awh_d = 1'b0;
         wh_d  = 1'b0;
         bv_d  = 1'b1;
         br_d  = RESP_OKAY;
         if (awa_q == CTRL_OFS) begin
            fn_d   = wst_q[0] ? wda_q[CTRL_FN_LSB +: 2] : fn_q;
            unit_d = wst_q[0] ? wda_q[CTRL_UNIT_LSB +: 3] : unit_q;
         end else if (awa_q == OFFSET_OFS) begin
            off_d = clamp_val(merge(off_q, wda_q, wst_q));
         end else if (wx[4]) begin
            xd[wx[3:0]] = clamp_val(merge(xq[wx[3:0]], wda_q, wst_q));
         end else if (wy[4]) begin
            yd[wy[3:0]] = clamp_val(merge(yq[wy[3:0]], wda_q, wst_q));
         end else if (awa_q != STATUS_OFS && awa_q != RESULT_OFS) begin
            br_d = RESP_SLV;
         end
      end
      if (rv_q && s_axi_rready) rv_d = 1'b0;
      if (s_axi_arvalid && arr_q) begin
         rv_d = 1'b1;
         rr_d = RESP_OKAY;
         rd_d = RST_VAL;
         if (s_axi_araddr == CTRL_OFS) begin
            rd_d[CTRL_FN_LSB +: 2]   = fn_q;
            rd_d[CTRL_UNIT_LSB +: 3] = unit_q;
         end else if (s_axi_araddr == OFFSET_OFS) begin
            rd_d = off_q;
         end else if (s_axi_araddr == STATUS_OFS) begin
            rd_d[ST_BUSY_BIT] = busy_q;
            rd_d[ST_ERR_BIT]  = err_q;
            rd_d[ST_SEEN_BIT] = seen_q;
         end else if (s_axi_araddr == RESULT_OFS) begin
            rd_d = out_value;
         end else if (rx[4]) begin
            rd_d = xq[rx[3:0]];
         end else if (ry[4]) begin
            rd_d = yq[ry[3:0]];
         end else begin
            rr_d = RESP_SLV;
         end
      end
      // one write and one read outstanding at most
      awr_d = !awh_d && !bv_d;
      wr_d  = !wh_d && !bv_d;
      arr_d = !rv_d;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 0; k < NPTS; k++) begin
            xq[k] <= RST_VAL;
            yq[k] <= RST_VAL;
         end
         fn_q <= FN_OFF;
         unit_q <= UNIT_SOURCE;
         off_q <= RST_VAL;
         awa_q <= 8'h00;
         awh_q <= 1'b0;
         awr_q <= 1'b1;
         wda_q <= RST_VAL;
         wst_q <= 4'h0;
         wh_q <= 1'b0;
         wr_q <= 1'b1;
         bv_q <= 1'b0;
         br_q <= RESP_OKAY;
         arr_q <= 1'b1;
         rv_q <= 1'b0;
         rr_q <= RESP_OKAY;
         rd_q <= RST_VAL;
      end else begin
         xq <= xd;
         yq <= yd;
         fn_q <= fn_d;
         unit_q <= unit_d;
         off_q <= off_d;
         awa_q <= awa_d;
         awh_q <= awh_d;
         awr_q <= awr_d;
         wda_q <= wda_d;
         wst_q <= wst_d;
         wh_q <= wh_d;
         wr_q <= wr_d;
         bv_q <= bv_d;
         br_q <= br_d;
         arr_q <= arr_d;
         rv_q <= rv_d;
         rr_q <= rr_d;
         rd_q <= rd_d;
      end
   end
   assign s_axi_awready = awr_q;
   assign s_axi_wready  = wr_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_arready = arr_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rresp   = rr_q;
   assign s_axi_rdata   = rd_q;
   // ------------------------------------------------
   // evaluation
   // ------------------------------------------------
   state_t st_q, st_d;
   logic [3:0]  hi, nx;
   logic        le_first, exact, take, go_div;
   logic signed [31:0] dxin, dx, dy, direct;
   logic [31:0] base_q, base_d, den_q, den_d, quo, scaled;
   logic [63:0] num_q, num_d;
   logic        neg_q, neg_d, div_done;
   logic [2:0]  pu_q, pu_d, ou_d;
   logic        ov_d, oe_d, rdy_d, busy_d, err_d, seen_d;
   logic [31:0] ovl_d;
   seg_finder #(.N(NPTS), .W(DW)) u_find (
      .xs       (xq),
      .value    ($signed(in_value)),
      .hi       (hi),
      .le_first (le_first),
      .exact    (exact)
   );
   seq_divider #(.W(DW)) u_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (st_q == ST_LOAD),
      .num     (num_q),
      .den     (den_q),
      .quo     (quo),
      .done    (div_done)
   );
   always_comb begin
      take = in_valid && in_ready;
      nx   = (hi == 4'(NPTS - 1)) ? hi : hi + 4'h1;
      dxin = $signed(in_value) - xq[hi];
      dx   = xq[nx] - xq[hi];
      dy   = yq[nx] - yq[hi];
      go_div = 1'b0;
      unique case (fn_q)
         FN_INTERP: begin
            if (le_first) begin
               direct = yq[0];
            end else if (exact || hi == 4'(NPTS - 1)) begin
               direct = yq[hi];
            end else begin
               direct = yq[hi];
               go_div = !in_error;
            end
         end
         FN_STEP: direct = yq[hi];
         default: direct = $signed(in_value);
      endcase
      st_d = st_q;
      base_d = base_q;
      num_d = num_q;
      den_d = den_q;
      neg_d = neg_q;
      pu_d = pu_q;
      ov_d = 1'b0;
      ovl_d = out_value;
      oe_d = out_error;
      ou_d = out_unit;
      scaled = base_q + (neg_q ? 32'(-quo) : quo);
      err_d = err_q;
      seen_d = seen_q;
      unique case (st_q)
         ST_IDLE: if (take) begin
            pu_d = (unit_q == UNIT_SOURCE) ? in_unit : unit_q;
            if (go_div) begin
               // dx > 0 here: hi is the last point not above the input
               base_d = direct;
               num_d = 64'(unsigned'(dxin)) * 64'(dy[31] ? -dy : dy);
               den_d = dx;
               neg_d = dy[31];
               st_d = ST_LOAD;
            end else begin
               ov_d  = 1'b1;
               oe_d  = in_error;
               ovl_d = in_error ? RST_VAL : direct + off_q;
               ou_d  = pu_d;
            end
         end
         ST_LOAD: st_d = ST_DIV;
         ST_DIV: if (div_done) begin
            ov_d  = 1'b1;
            oe_d  = 1'b0;
            ovl_d = scaled + off_q;
            ou_d  = pu_q;
            st_d  = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
      if (ov_d) begin
         err_d  = oe_d;
         seen_d = 1'b1;
      end
      rdy_d  = (st_d == ST_IDLE);
      busy_d = !rdy_d;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_IDLE;
         base_q <= RST_VAL;
         num_q <= 64'h0;
         den_q <= RST_VAL;
         neg_q <= 1'b0;
         pu_q <= UNIT_SOURCE;
         out_valid <= 1'b0;
         out_value <= RST_VAL;
         out_error <= 1'b0;
         out_unit <= UNIT_SOURCE;
         in_ready <= 1'b1;
         busy_q <= 1'b0;
         err_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         st_q <= st_d;
         base_q <= base_d;
         num_q <= num_d;
         den_q <= den_d;
         neg_q <= neg_d;
         pu_q <= pu_d;
         out_valid <= ov_d;
         out_value <= ovl_d;
         out_error <= oe_d;
         out_unit <= ou_d;
         in_ready <= rdy_d;
         busy_q <= busy_d;
         err_q <= err_d;
         seen_q <= seen_d;
      end
   end
   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   off_pass_a: assert property (take && fn_q == FN_OFF && !in_error |=>
      out_valid && out_value == $past(in_value) + $past(off_q))
      else $error("off mode result wrong");
   step_low_a: assert property (take && fn_q == FN_STEP && !in_error &&
      $signed(in_value) < xq[1] |=> out_value == $past(yq[0]) + $past(off_q))
      else $error("stepped low result wrong");
   step_hold_a: assert property (take && fn_q == FN_STEP && !in_error |=>
      out_value == $past(yq[hi]) + $past(off_q))
      else $error("stepped result wrong");
   first_pt_a: assert property (take && fn_q == FN_INTERP && !in_error &&
      le_first |=> out_value == $past(yq[0]) + $past(off_q))
      else $error("first point clamp wrong");
   exact_pt_a: assert property (take && fn_q == FN_INTERP && !in_error &&
      exact && !le_first |=> out_value == $past(yq[hi]) + $past(off_q))
      else $error("exact point result wrong");
   err_prop_a: assert property (take && in_error |=>
      out_valid && out_error)
      else $error("error not propagated");
   unit_src_a: assert property (take && unit_q == UNIT_SOURCE && !go_div |=>
      out_unit == $past(in_unit))
      else $error("source unit not copied");
   interp_lat_a: assert property (take && go_div |=>
      !out_valid [*8] ##58 !out_valid ##1 out_valid)
      else $error("interpolation latency wrong");
   off_range_a: assert property ($signed(off_q) <= $signed(VAL_MAX) &&
      $signed(off_q) >= $signed(VAL_MIN))
      else $error("offset out of range");
   cov_off_c:    cover property (take && fn_q == FN_OFF);
   cov_interp_c: cover property (take && go_div ##67 out_valid);
   cov_step_c:   cover property (take && fn_q == FN_STEP && hi == 4'h9);
   cov_err_c:    cover property (take && in_error);
endmodule
`default_nettype wire

// ---- rtl/lin_pkg.sv ----
// constants shared by the ten point linearizer and its helpers
// assumes one 100 MHz clock and milli-unit fixed point values
`default_nettype none
package lin_pkg;
   // -----------------------------------------
   // curve shape and value format
   // -----------------------------------------
   localparam int NPTS = 10;
   localparam int DW   = 32;
   // milli-units: 99999.000 and -99999.000
   localparam logic [31:0] VAL_MAX = 32'h05F5DD18;
   localparam logic [31:0] VAL_MIN = 32'hFA0A22E8;
   // -----------------------------------------
   // register map
   // -----------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] OFFSET_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] RESULT_OFS = 8'h0C;
   localparam logic [7:0] XPT_BASE   = 8'h40;
   localparam logic [7:0] YPT_BASE   = 8'h80;
   localparam int CTRL_FN_LSB   = 0;
   localparam int CTRL_UNIT_LSB = 4;
   localparam int ST_BUSY_BIT   = 0;
   localparam int ST_ERR_BIT    = 1;
   localparam int ST_SEEN_BIT   = 2;
   localparam logic [31:0] RST_VAL  = 32'h00000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLV  = 2'h2;
   // -----------------------------------------
   // modes, units, states
   // -----------------------------------------
   localparam logic [2:0] UNIT_SOURCE = 3'h0;
   localparam logic [2:0] UNIT_NONE   = 3'h1;
   localparam logic [2:0] UNIT_ABS_T  = 3'h2;
   localparam logic [2:0] UNIT_REL_T  = 3'h3;
   localparam logic [2:0] UNIT_POWER  = 3'h4;
   localparam logic [2:0] UNIT_PROC   = 3'h5;
   localparam logic [2:0] UNIT_RH     = 3'h6;
   localparam int DIV_CYCLES = 64;
   typedef enum logic [1:0] {
      FN_OFF    = 2'b00,
      FN_INTERP = 2'b01,
      FN_STEP   = 2'b10
   } func_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_DIV  = 2'b10
   } state_t;
endpackage
`default_nettype wire

// ---- rtl/seg_finder.sv ----
// locates the curve segment that holds a value
// assumes point inputs ascend; equal points are simply passed over
`timescale 1ns/1ps
`default_nettype none
module seg_finder
   import lin_pkg::*;
#(
   parameter int N = NPTS,
   parameter int W = DW
) (
   // curve and probe
   input  wire logic signed [W-1:0] xs [N],
   input  wire logic signed [W-1:0] value,
   // result
   output logic [3:0]               hi,
   output logic                     le_first,
   output logic                     exact
);
   if (N < 2 || N > 16) begin : g_chk
      $error("seg_finder: N out of range");
   end
   always_comb begin
      hi = 4'h0;
      // last point at or below wins, so zero width segments drop out
      for (int k = 1; k < N; k++) begin
         if (xs[k] <= value) begin
            hi = 4'(k);
         end
      end
      le_first = (value <= xs[0]);
      exact    = (value == xs[hi]);
   end
endmodule
`default_nettype wire

// ---- rtl/seq_divider.sv ----
// unsigned restoring divider, one quotient bit a cycle
// assumes the quotient fits W bits; start only while idle
`timescale 1ns/1ps
`default_nettype none
module seq_divider
   import lin_pkg::*;
#(
   parameter int W = DW
) (
   // clock and reset
   input  wire logic           aclk,
   input  wire logic           aresetn,
   // operands
   input  wire logic           start,
   input  wire logic [2*W-1:0] num,
   input  wire logic [W-1:0]   den,
   // result
   output logic [W-1:0]        quo,
   output logic                done
);
   if (W < 8 || 2 * W != DIV_CYCLES) begin : g_chk
      $error("seq_divider: W must be half of DIV_CYCLES");
   end
   logic [W-1:0]   rem_q, rem_d;
   logic [2*W-1:0] q_q, q_d;
   logic [6:0]     cnt_q, cnt_d;
   logic           done_q, done_d;
   logic [W:0]     trial;
   always_comb begin
      rem_d  = rem_q;
      q_d    = q_q;
      cnt_d  = cnt_q;
      done_d = 1'b0;
      trial  = {rem_q, q_q[2*W-1]};
      if (start) begin
         rem_d = '0;
         q_d   = num;
         cnt_d = 7'(DIV_CYCLES);
      end else if (cnt_q != 7'h00) begin
         if (trial >= {1'b0, den}) begin
            rem_d = W'(trial - {1'b0, den});
            q_d   = {q_q[2*W-2:0], 1'b1};
         end else begin
            rem_d = trial[W-1:0];
            q_d   = {q_q[2*W-2:0], 1'b0};
         end
         cnt_d  = cnt_q - 7'h01;
         done_d = (cnt_q == 7'h01);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rem_q  <= '0;
         q_q    <= '0;
         cnt_q  <= 7'h00;
         done_q <= 1'b0;
      end else begin
         rem_q  <= rem_d;
         q_q    <= q_d;
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end
   assign quo  = q_q[W-1:0];
   assign done = done_q;
endmodule
`default_nettype wire

// ---- bench/sample_peer.sv ----
// model of the neighbouring blocks: offers samples, collects results
// assumes the block takes a sample at an edge with in_valid and in_ready high
`timescale 1ns/1ps
`default_nettype none
module sample_peer (
   // clock and block status
   input  wire logic        aclk,
   input  wire logic        in_ready,
   input  wire logic        out_valid,
   input  wire logic [31:0] out_value,
   input  wire logic        out_error,
   input  wire logic [2:0]  out_unit,
   // sample to the block
   output var logic         in_valid,
   output var logic [31:0]  in_value,
   output var logic         in_error,
   output var logic [2:0]   in_unit
);
   logic [31:0] res_value;
   logic        res_error;
   logic [2:0]  res_unit;
   int          n_res = 0;
   initial begin
      in_valid = 1'b0;
      in_value = 32'h0;
      in_error = 1'b0;
      in_unit = 3'h0;
   end
   // -----------------------------------------
   // offer one sample, hold it until taken
   // -----------------------------------------
   task automatic send(input logic [31:0] v, input logic e, input logic [2:0] u);
      in_value <= v;
      in_error <= e;
      in_unit <= u;
      in_valid <= 1'b1;
      do @(posedge aclk); while (in_ready !== 1'b1);
      in_valid <= 1'b0;
      // released lines show junk so a stale value cannot pass
      in_value <= ~v;
      in_error <= ~e;
      in_unit <= ~u;
   endtask
   // -----------------------------------------
   // result capture, out_valid lasts one cycle
   // -----------------------------------------
   always @(posedge aclk) begin
      if (out_valid === 1'b1) begin
         res_value <= out_value;
         res_error <= out_error;
         res_unit <= out_unit;
         n_res <= n_res + 1;
      end
   end
endmodule
`default_nettype wire

// ---- bench/ten_point_linearizer_bench.sv ----
// testbench for the ten point linearizer: table of samples, then edge cases
// assumes sample_peer on the sample side and the lin_pkg register map
`timescale 1ns/1ps
`default_nettype none
module ten_point_linearizer_bench;
   import lin_pkg::*;
   logic        aclk, aresetn, in_valid, in_ready, in_error, out_valid, out_error;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, in_value, out_value, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [2:0]  in_unit, out_unit, eu;
   int          failures = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          n0;
   typedef struct packed {
      logic [1:0] fn; logic [2:0] unit; logic [31:0] x; logic err; logic [31:0] exp;
   } row_t;
   // curve: x = 1000k, y = 2000k + 500, offset 100 (milli-units)
   row_t rows [11] = '{
      '{2'h0, 3'h1, 32'h000004D2, 1'b0, 32'h00000536},
      '{2'h3, 3'h2, 32'h000004D2, 1'b0, 32'h00000536},
      '{2'h1, 3'h3, 32'h000005DC, 1'b0, 32'h00000E10},
      '{2'h1, 3'h4, 32'hFFFFEC78, 1'b0, 32'h00000258},
      '{2'h1, 3'h5, 32'h00002328, 1'b0, 32'h000048A8},
      '{2'h1, 3'h6, 32'h00004E20, 1'b0, 32'h000048A8},
      '{2'h1, 3'h0, 32'h00000FA0, 1'b0, 32'h00002198},
      '{2'h2, 3'h1, 32'h000003E7, 1'b0, 32'h00000258},
      '{2'h2, 3'h0, 32'h000003E8, 1'b0, 32'h00000A28},
      '{2'h2, 3'h2, 32'h000005DC, 1'b0, 32'h00000A28},
      '{2'h1, 3'h0, 32'h000005DC, 1'b1, 32'h00000000}};
   ten_point_linearizer dut_u (.*);
   sample_peer peer_u (.*);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // -----------------------------------------
   // checks, bus cycles, samples
   // -----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_axi_awready === 1'b1) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   task automatic sample(input logic [31:0] x, input logic e);
      n0 = peer_u.n_res;
      peer_u.send(x, e, 3'h3);
      while (peer_u.n_res == n0) @(posedge aclk);
   endtask
   task automatic end_of_test();
      if (failures == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         end_of_test();
      end
   end
   // -----------------------------------------
   // main sequence
   // -----------------------------------------
   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      // answer channels stay ready, so no edge sees a release and a raise at once
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_reg(CTRL_OFS);
      chk(rd, RST_VAL);
      rd_reg(YPT_BASE + 8'h24);
      chk(rd, RST_VAL);
      rd_reg(8'h20);
      chk({30'h0, rsp}, {30'h0, RESP_SLV});
      wr(8'h22, 32'h1);
      chk({30'h0, rsp}, {30'h0, RESP_SLV});
      wr(OFFSET_OFS, 32'h7FFFFFFF);
      rd_reg(OFFSET_OFS);
      chk(rd, VAL_MAX);
      wr(OFFSET_OFS, 32'h80000000);
      rd_reg(OFFSET_OFS);
      chk(rd, VAL_MIN);
      wr(OFFSET_OFS, 32'h00000064);
      // points loaded ascending, all ten used
      for (int k = 0; k < 10; k++) begin
         wr(XPT_BASE + 8'(4 * k), 32'(32'h3E8 * k));
         wr(YPT_BASE + 8'(4 * k), 32'(32'h7D0 * k + 32'h1F4));
      end
      rd_reg(XPT_BASE + 8'h24);
      chk(rd, 32'h00002328);
      foreach (rows[i]) begin
         wr(CTRL_OFS, {25'h0, rows[i].unit, 2'h0, rows[i].fn});
         sample(rows[i].x, rows[i].err);
         chk(peer_u.res_value, rows[i].exp);
         chk({31'h0, peer_u.res_error}, {31'h0, rows[i].err});
         eu = (rows[i].unit == 3'h0) ? 3'h3 : rows[i].unit;
         chk({29'h0, peer_u.res_unit}, {29'h0, eu});
      end
      // busy and not ready while interpolating
      wr(CTRL_OFS, 32'h00000001);
      n0 = peer_u.n_res;
      peer_u.send(32'h00001D4C, 1'b0, 3'h1);
      @(posedge aclk);
      chk({31'h0, in_ready}, 32'h0);
      rd_reg(STATUS_OFS);
      chk({31'h0, rd[ST_BUSY_BIT]}, 32'h1);
      while (peer_u.n_res == n0) @(posedge aclk);
      chk(peer_u.res_value, 32'h00003CF0);
      rd_reg(RESULT_OFS);
      chk(rd, 32'h00003CF0);
      // points nine and ten copy point eight: flat tail, equal points never divide
      for (int k = 8; k < 10; k++) begin
         wr(XPT_BASE + 8'(4 * k), 32'h00001B58);
         wr(YPT_BASE + 8'(4 * k), 32'h000038A4);
      end
      sample(32'h00001D4C, 1'b0);
      chk(peer_u.res_value, 32'h00003908);
      // second reset in mid-run clears the offset
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(out_value, RST_VAL);
      rd_reg(OFFSET_OFS);
      chk(rd, RST_VAL);
      end_of_test();
   end
endmodule
`default_nettype wire
